// ==== core/ioc_params.svh ====
// Constants of the IO-setup command handler: layout, codes, reset values.
`ifndef IOC_PARAMS_SVH
`define IOC_PARAMS_SVH

// ----------------------------------------------------------------------
// Packet layout
// ----------------------------------------------------------------------
`define IOC_PKT_LEN        12
`define IOC_LAST_IDX       4'hB
`define IOC_HDR_B1         8'hF8
`define IOC_HDR_B2         8'h03
`define IOC_HDR_B3         8'h0B
`define IOC_B_HSUM         0
`define IOC_B_PSUM_LO      4
`define IOC_B_PSUM_HI      5
`define IOC_B_MASK         6
`define IOC_B_RSV          7
`define IOC_B_TC           8
`define IOC_B_DAC          9
`define IOC_B_FLEX         10
`define IOC_B_EXT          11
`define IOC_FIRST_PAYLOAD  6

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define IOC_MB_TC          0
`define IOC_MB_DAC         1
`define IOC_MB_FLEX        2
`define IOC_MB_EXT         3
`define IOC_MB_SER         5
`define IOC_TC_OFF_MSB     7
`define IOC_TC_OFF_LSB     4
`define IOC_TC_C1          3
`define IOC_TC_C0          2
`define IOC_TC_NT_MSB      1
`define IOC_DC_SER         2
`define IOC_DC_EN          0

// ----------------------------------------------------------------------
// Limits, codes and reset values
// ----------------------------------------------------------------------
`define IOC_OFF_MIN        4'h4
`define IOC_OFF_MAX        4'h8
`define IOC_MAX_TIMERS     2'h2
`define IOC_SRC_DIV_MIN    3'h3
`define IOC_SRC_DIV_MAX    3'h6
`define IOC_TIMER_MODE     4'hA
`define IOC_ERR_NONE       8'h00
`define IOC_ERR_SUM        8'h01
`define IOC_ERR_HDR        8'h02
`define IOC_ERR_OFFSET     8'h03
`define IOC_ERR_COMBO      8'h04
`define IOC_RST_TC         8'h40
`define IOC_RST_DAC        8'h00
`define IOC_RST_FLEX       8'h00
`define IOC_RST_EXT        8'h00

`endif

// ==== core/ioc_pkg.sv ====
// Types shared by the IO-setup command handler.
package ioc_pkg;

   typedef logic [11:0][7:0] ioc_pkt_t;

   typedef enum logic [1:0] {
      IOC_RX,
      IOC_EXEC,
      IOC_SUM,
      IOC_TX
   } ioc_state_t;

   typedef struct packed {
      ioc_state_t state;
      logic [3:0] idx;
      ioc_pkt_t   pkt;
      ioc_pkt_t   rsp;
      logic [7:0] tc_setup;
      logic [7:0] dac_ctl;
      logic [7:0] flex;
      logic [7:0] ext;
      logic [4:0] t0_line;
      logic [4:0] t1_line;
      logic [4:0] c0_line;
      logic [4:0] c1_line;
      logic       c0_live;
      logic       dac_on;
      logic       ser_on;
      logic       mode_reset;
   } ioc_regs_t;

endpackage

// ==== core/ioc_sum_if.sv ====
// Carrier between a packet and its checksum calculator.
`timescale 1ns/100ps
interface ioc_sum_if;
   ioc_pkg::ioc_pkt_t pkt;
   logic [7:0]        header_sum;
   logic [15:0]       payload_sum;

   modport calc (input pkt, output header_sum, output payload_sum);
   modport user (output pkt, input header_sum, input payload_sum);
endinterface

// ==== core/ioc_pkt_sum.sv ====
// Header and payload checksums of one packet.
`timescale 1ns/100ps
`include "ioc_params.svh"
module ioc_pkt_sum #(
   parameter int FIRST = `IOC_FIRST_PAYLOAD
) (
   ioc_sum_if.calc s
);
   logic [15:0] psum;
   logic [15:0] hsum;
   logic [15:0] fold;

   // The header sum covers bytes 1..5, with 4 and 5 taken from the
   // computed payload sum so the same unit can build a response.
   always_comb begin
      psum = 16'h0000;
      for (int i = FIRST; i < `IOC_PKT_LEN; i++) begin
         psum = psum + {8'h00, s.pkt[i]};
      end
      hsum = {8'h00, s.pkt[1]} + {8'h00, s.pkt[2]} + {8'h00, s.pkt[3]}
           + {8'h00, psum[7:0]} + {8'h00, psum[15:8]};
      fold = {8'h00, hsum[7:0]} + {8'h00, hsum[15:8]};
      fold = {8'h00, fold[7:0]} + {8'h00, fold[15:8]};
   end

   assign s.payload_sum = psum;
   assign s.header_sum  = fold[7:0];
endmodule // ioc_pkt_sum

// ==== core/ioc_handler.sv ====
// IO-setup command handler: packet intake, checks, masked update, reply.
// Functional notes
// - Fixed twelve-byte packets with F8 03 0B header.
// - Byte 6 mask selects which fields update.
// - Mask bits 0,1 gate setup byte and DAC enable bit.
// - Mask bit 5 gates serial-port settings.
// - Byte 8: offset, counter enables, timer count.
// - Setup bit 3 enables second counter.
// - Setup bit 2 enables first counter.
// - Lines start at flex line zero plus offset.
// - Revision 1.30 accepts offsets four to eight.
// - Order: timers first, then both counters.
// - Timers enabled: every timer returns to mode ten.
// - Divisor clock sources block the first counter.
// - Revision 1.30: byte 9 bit 2 assigns serial lines.
// - Serial assign bit needs mask bit 5.
// - Old revisions: byte 9 bit 0 enables DAC.
// - Byte 10 bits: flex line analog or digital.
// - Byte 11 bits: ext line analog or digital.
`timescale 1ns/100ps
`include "ioc_params.svh"
module ioc_handler (
   input  wire logic       i_mclk,
   input  wire logic       i_sys_rst,
   input  wire logic       i_hw_rev_130,
   input  wire logic [2:0] i_timer_clock_source,
   input  wire logic       i_cmd_valid,
   input  wire logic [7:0] i_cmd_byte,
   output logic            o_cmd_ready,
   output logic            o_rsp_valid,
   output logic [7:0]      o_rsp_byte,
   input  wire logic       i_rsp_ready,
   output logic [7:0]      o_timer_counter_setup,
   output logic [7:0]      o_second_dac_control,
   output logic [7:0]      o_flex_port_analog_select,
   output logic [7:0]      o_ext_port_analog_select,
   output logic [3:0]      o_start_pin_offset,
   output logic            o_first_timer_enable,
   output logic            o_second_timer_enable,
   output logic            o_first_counter_enable,
   output logic            o_second_counter_enable,
   output logic [4:0]      o_first_timer_line,
   output logic [4:0]      o_second_timer_line,
   output logic [4:0]      o_first_counter_line,
   output logic [4:0]      o_second_counter_line,
   output logic            o_second_dac_enable,
   output logic            o_serial_pins_assigned,
   output logic            o_timer_mode_reset,
   output logic [3:0]      o_timer_reset_mode
);

   // -------------------------------------------------------------------
   // Checksum units
   // -------------------------------------------------------------------
   ioc_sum_if rx_sum ();
   ioc_sum_if tx_sum ();

   ioc_pkt_sum #(.FIRST(`IOC_FIRST_PAYLOAD)) u_rx_sum (.s(rx_sum.calc));
   ioc_pkt_sum #(.FIRST(`IOC_FIRST_PAYLOAD)) u_tx_sum (.s(tx_sum.calc));

   ioc_pkg::ioc_regs_t st;
   ioc_pkg::ioc_regs_t next_st;

   assign rx_sum.pkt = st.pkt;
   assign tx_sum.pkt = st.rsp;

   // -------------------------------------------------------------------
   // Command decode
   // -------------------------------------------------------------------
   logic [7:0] mask;
   logic [7:0] req_tc;
   logic [3:0] req_off;
   logic       hdr_bad;
   logic       sum_bad;
   logic       off_bad;
   logic       combo_bad;
   logic       src_div;
   logic [7:0] err;

   always_comb begin
      mask    = st.pkt[`IOC_B_MASK];
      req_tc  = st.pkt[`IOC_B_TC];
      req_off = req_tc[`IOC_TC_OFF_MSB:`IOC_TC_OFF_LSB];
      src_div = (i_timer_clock_source >= `IOC_SRC_DIV_MIN)
             && (i_timer_clock_source <= `IOC_SRC_DIV_MAX);
      hdr_bad = (st.pkt[1] != `IOC_HDR_B1)
             || (st.pkt[2] != `IOC_HDR_B2)
             || (st.pkt[3] != `IOC_HDR_B3);
      sum_bad = (st.pkt[`IOC_B_HSUM] != rx_sum.header_sum)
             || ({st.pkt[`IOC_B_PSUM_HI], st.pkt[`IOC_B_PSUM_LO]}
                 != rx_sum.payload_sum);
      // Offsets are only checked when the setup byte is being written.
      off_bad = mask[`IOC_MB_TC] && i_hw_rev_130
             && ((req_off < `IOC_OFF_MIN) || (req_off > `IOC_OFF_MAX));
      combo_bad = mask[`IOC_MB_TC]
             && ((req_tc[`IOC_TC_NT_MSB:0] > `IOC_MAX_TIMERS)
                 || (req_tc[`IOC_TC_C0] && src_div));
      if (sum_bad) begin
         err = `IOC_ERR_SUM;
      end else if (hdr_bad) begin
         err = `IOC_ERR_HDR;
      end else if (off_bad) begin
         err = `IOC_ERR_OFFSET;
      end else if (combo_bad) begin
         err = `IOC_ERR_COMBO;
      end else begin
         err = `IOC_ERR_NONE;
      end
   end

   // -------------------------------------------------------------------
   // Next state
   // -------------------------------------------------------------------
   logic [1:0] ntim;
   logic [4:0] base;

   always_comb begin
      next_st            = st;
      next_st.mode_reset = 1'b0;
      ntim               = 2'h0;
      base               = 5'h00;
      unique case (st.state)
         ioc_pkg::IOC_RX: begin
            if (i_cmd_valid) begin
               next_st.pkt[st.idx] = i_cmd_byte;
               if (st.idx == `IOC_LAST_IDX) begin
                  next_st.idx   = 4'h0;
                  next_st.state = ioc_pkg::IOC_EXEC;
               end else begin
                  next_st.idx = st.idx + 4'h1;
               end
            end
         end
         ioc_pkg::IOC_EXEC: begin
            // A rejected command leaves every field as it was.
            if (err == `IOC_ERR_NONE) begin
               if (mask[`IOC_MB_TC]) begin
                  next_st.tc_setup = req_tc;
               end
               if (mask[`IOC_MB_DAC]) begin
                  next_st.dac_ctl[`IOC_DC_EN] =
                     st.pkt[`IOC_B_DAC][`IOC_DC_EN];
               end
               if (mask[`IOC_MB_SER]) begin
                  next_st.dac_ctl[`IOC_DC_SER] =
                     st.pkt[`IOC_B_DAC][`IOC_DC_SER];
               end
               if (mask[`IOC_MB_FLEX]) begin
                  next_st.flex = st.pkt[`IOC_B_FLEX];
               end
               if (mask[`IOC_MB_EXT]) begin
                  next_st.ext = st.pkt[`IOC_B_EXT];
               end
               next_st.mode_reset =
                  (next_st.tc_setup[`IOC_TC_NT_MSB:0] != 2'h0);
            end
            // Lines are handed out in a fixed order from the offset on.
            ntim = next_st.tc_setup[`IOC_TC_NT_MSB:0];
            base = {1'b0, next_st.tc_setup[`IOC_TC_OFF_MSB:
                                            `IOC_TC_OFF_LSB]};
            next_st.t0_line = base;
            next_st.t1_line = base + 5'h01;
            next_st.c0_line = base + {3'h0, ntim};
            next_st.c1_line = base + {3'h0, ntim}
                            + {4'h0, next_st.tc_setup[`IOC_TC_C0]};
            next_st.rsp      = '0;
            next_st.rsp[1]   = `IOC_HDR_B1;
            next_st.rsp[2]   = `IOC_HDR_B2;
            next_st.rsp[3]   = `IOC_HDR_B3;
            next_st.rsp[`IOC_B_MASK] = err;
            next_st.rsp[`IOC_B_TC]   = next_st.tc_setup;
            next_st.rsp[`IOC_B_DAC]  = next_st.dac_ctl;
            next_st.rsp[`IOC_B_FLEX] = next_st.flex;
            next_st.rsp[`IOC_B_EXT]  = next_st.ext;
            next_st.state = ioc_pkg::IOC_SUM;
         end
         ioc_pkg::IOC_SUM: begin
            next_st.rsp[`IOC_B_HSUM]    = tx_sum.header_sum;
            next_st.rsp[`IOC_B_PSUM_LO] = tx_sum.payload_sum[7:0];
            next_st.rsp[`IOC_B_PSUM_HI] = tx_sum.payload_sum[15:8];
            next_st.state = ioc_pkg::IOC_TX;
         end
         ioc_pkg::IOC_TX: begin
            if (i_rsp_ready) begin
               next_st.rsp = {8'h00, st.rsp[11:1]};
               if (st.idx == `IOC_LAST_IDX) begin
                  next_st.idx   = 4'h0;
                  next_st.state = ioc_pkg::IOC_RX;
               end else begin
                  next_st.idx = st.idx + 4'h1;
               end
            end
         end
      endcase
      // The clock source may change at any time, so the counter gate
      // is re-evaluated every cycle rather than only on a command.
      next_st.c0_live = next_st.tc_setup[`IOC_TC_C0] && !src_div;
      // From revision 1.30 on the DAC is always on and the serial
      // assignment exists; older parts use only the enable bit.
      next_st.dac_on = i_hw_rev_130
                    || next_st.dac_ctl[`IOC_DC_EN];
      next_st.ser_on = i_hw_rev_130
                    && next_st.dac_ctl[`IOC_DC_SER];
   end

   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         st          <= '0;
         st.state    <= ioc_pkg::IOC_RX;
         st.tc_setup <= `IOC_RST_TC;
         st.dac_ctl  <= `IOC_RST_DAC;
         st.flex     <= `IOC_RST_FLEX;
         st.ext      <= `IOC_RST_EXT;
         st.t0_line  <= 5'h04;
         st.t1_line  <= 5'h05;
         st.c0_line  <= 5'h04;
         st.c1_line  <= 5'h04;
      end else begin
         st <= next_st;
      end
   end

   // -------------------------------------------------------------------
   // Outputs
   // -------------------------------------------------------------------
   assign o_cmd_ready               = (st.state == ioc_pkg::IOC_RX);
   assign o_rsp_valid               = (st.state == ioc_pkg::IOC_TX);
   assign o_rsp_byte                = st.rsp[0];
   assign o_timer_counter_setup     = st.tc_setup;
   assign o_second_dac_control      = st.dac_ctl;
   assign o_flex_port_analog_select = st.flex;
   assign o_ext_port_analog_select  = st.ext;
   assign o_start_pin_offset =
      st.tc_setup[`IOC_TC_OFF_MSB:`IOC_TC_OFF_LSB];
   assign o_first_timer_enable  = (st.tc_setup[`IOC_TC_NT_MSB:0] != 2'h0);
   assign o_second_timer_enable = st.tc_setup[`IOC_TC_NT_MSB];
   assign o_first_counter_enable  = st.c0_live;
   assign o_second_counter_enable = st.tc_setup[`IOC_TC_C1];
   assign o_first_timer_line    = st.t0_line;
   assign o_second_timer_line   = st.t1_line;
   assign o_first_counter_line  = st.c0_line;
   assign o_second_counter_line = st.c1_line;
   assign o_second_dac_enable    = st.dac_on;
   assign o_serial_pins_assigned = st.ser_on;
   assign o_timer_mode_reset     = st.mode_reset;
   assign o_timer_reset_mode     = `IOC_TIMER_MODE;

   // -------------------------------------------------------------------
   // Checks
   // -------------------------------------------------------------------
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (i_sys_rst);

   logic in_exec;
   logic ok_exec;
   assign in_exec = (st.state == ioc_pkg::IOC_EXEC);
   assign ok_exec = in_exec && (err == `IOC_ERR_NONE);

   reply_header_a: assert property ($rose(o_rsp_valid) |->
      st.rsp[1] == `IOC_HDR_B1 && st.rsp[2] == `IOC_HDR_B2
      && st.rsp[3] == `IOC_HDR_B3)
      else $error("reply header bytes wrong");

   flex_hold_a: assert property (in_exec && !mask[`IOC_MB_FLEX]
      |=> $stable(o_flex_port_analog_select))
      else $error("flex select changed without mask bit");

   setup_write_a: assert property (ok_exec && mask[`IOC_MB_TC]
      |=> o_timer_counter_setup == $past(req_tc))
      else $error("setup byte not written");

   serial_gate_a: assert property (in_exec && !mask[`IOC_MB_SER]
      |=> $stable(st.dac_ctl[`IOC_DC_SER]))
      else $error("serial bit changed without mask bit");

   offset_range_a: assert property (in_exec && !sum_bad && !hdr_bad
      && off_bad |=> st.rsp[`IOC_B_MASK] == `IOC_ERR_OFFSET
      && $stable(o_timer_counter_setup))
      else $error("bad offset accepted");

   counter_block_a: assert property (o_first_counter_enable
      |-> !($past(i_timer_clock_source) >= `IOC_SRC_DIV_MIN
            && $past(i_timer_clock_source) <= `IOC_SRC_DIV_MAX))
      else $error("first counter on with divisor source");

   mode_reset_a: assert property (ok_exec
      && (o_timer_counter_setup[1:0] != 2'h0) && !mask[`IOC_MB_TC]
      |=> o_timer_mode_reset ##1 !o_timer_mode_reset)
      else $error("timer mode reset pulse missing");

   old_dac_a: assert property (!i_hw_rev_130 && ok_exec
      && mask[`IOC_MB_DAC] ##1 !i_hw_rev_130
      |-> o_second_dac_enable == $past(st.pkt[`IOC_B_DAC][0]))
      else $error("dac enable not taken");

   line_order_a: assert property (o_second_timer_enable
      |-> o_second_timer_line == o_first_timer_line + 5'h01
      && o_first_counter_line == o_first_timer_line + 5'h02)
      else $error("line order wrong");

   sum_reject_a: assert property (in_exec && sum_bad
      |=> st.rsp[`IOC_B_MASK] == `IOC_ERR_SUM
      && $stable(o_timer_counter_setup) ##[1:2] o_rsp_valid)
      else $error("bad checksum not rejected");

   ext_hold_a: assert property (in_exec && !mask[`IOC_MB_EXT]
      |=> $stable(o_ext_port_analog_select))
      else $error("ext select changed without mask bit");

   dac_gate_a: assert property (in_exec && !mask[`IOC_MB_DAC]
      |=> $stable(st.dac_ctl[`IOC_DC_EN]))
      else $error("dac bit changed without mask bit");

   error_hold_a: assert property (in_exec && err != `IOC_ERR_NONE
      |=> $stable(o_timer_counter_setup) && $stable(o_second_dac_control)
      && $stable(o_flex_port_analog_select)
      && $stable(o_ext_port_analog_select))
      else $error("rejected command changed the setup");

   mode_cause_a: assert property (!$past(ok_exec)
      |-> !o_timer_mode_reset)
      else $error("timer mode reset without a command");

   // Holds at all times, not only after a command, since the lines and
   // the setup byte are written on the same edge.
   counter_lines_a: assert property (o_second_counter_line
      == o_first_counter_line + {4'h0, o_timer_counter_setup[`IOC_TC_C0]})
      else $error("second counter line wrong");

   reply_hold_a: assert property (o_rsp_valid && !i_rsp_ready
      |=> o_rsp_valid && $stable(o_rsp_byte))
      else $error("reply byte moved while stalled");

   good_cmd_c: cover property (ok_exec ##2 o_rsp_valid);
   bad_sum_c: cover property (in_exec && sum_bad);
   mode_pulse_c: cover property (o_timer_mode_reset);
   stall_c: cover property (o_rsp_valid && !i_rsp_ready);
   old_rev_c: cover property (!i_hw_rev_130 && ok_exec);

endmodule // ioc_handler

// ==== testbench/ioc_host_model.sv ====
// Host model: sends one command packet and collects the reply.
`timescale 1ns/100ps
module ioc_host_model (
   input  wire logic       i_mclk,
   input  wire logic       i_cmd_ready,
   input  wire logic       i_rsp_valid,
   input  wire logic [7:0] i_rsp_byte,
   output logic            o_cmd_valid,
   output logic [7:0]      o_cmd_byte,
   output logic            o_rsp_ready
);
   initial begin
      o_cmd_valid = 1'b0;
      o_cmd_byte  = 8'h5A;
      o_rsp_ready = 1'b0;
   end

   // Pat is the reply stall pattern. Junk keeps the strobe up, last byte
   // held, during the reply, so that refused bytes are really offered.
   task automatic xfer(input ioc_pkg::ioc_pkt_t cmd, input logic [7:0] pat,
                       input logic junk, output ioc_pkg::ioc_pkt_t rsp,
                       output logic ok);
      int n;
      int k;
      n = 0;
      k = 0;
      rsp = '0;
      while (n < 12 && k < 100) begin
         o_cmd_valid = 1'b1;
         o_cmd_byte  = cmd[n];
         @(posedge i_mclk);
         if (i_cmd_ready === 1'b1) n++;
         k++;
         #1;
      end
      o_cmd_valid = junk;
      n = 0;
      while (n < 12 && k < 600) begin
         o_rsp_ready = pat[k % 8];
         @(posedge i_mclk);
         if (i_rsp_valid === 1'b1 && o_rsp_ready) begin
            rsp[n] = i_rsp_byte;
            n++;
         end
         k++;
         #1;
      end
      o_rsp_ready = 1'b0;
      o_cmd_valid = 1'b0;
      ok = (n == 12);
      // One idle edge keeps the next call from raising the strobe in the
      // same time step in which this one dropped it.
      @(posedge i_mclk);
      #1;
   endtask
endmodule // ioc_host_model

// ==== testbench/test_io_config_command_handler.sv ====
// Self-checking bench for the IO-setup command handler.
`timescale 1ns/100ps
`include "ioc_params.svh"
module test_io_config_command_handler;
   logic        i_mclk;
   logic        i_sys_rst;
   logic        i_hw_rev_130;
   logic [2:0]  i_timer_clock_source;
   logic        i_cmd_valid;
   logic [7:0]  i_cmd_byte;
   logic        i_rsp_ready;
   logic        o_cmd_ready, o_rsp_valid, o_first_timer_enable;
   logic        o_second_timer_enable, o_first_counter_enable;
   logic        o_second_counter_enable, o_second_dac_enable;
   logic        o_serial_pins_assigned, o_timer_mode_reset;
   logic [7:0]  o_rsp_byte, o_timer_counter_setup, o_second_dac_control;
   logic [7:0]  o_flex_port_analog_select, o_ext_port_analog_select;
   logic [3:0]  o_start_pin_offset, o_timer_reset_mode;
   logic [4:0]  o_first_timer_line, o_second_timer_line;
   logic [4:0]  o_first_counter_line, o_second_counter_line;
   logic [31:0] lfsr;
   logic [7:0]  e_tc, e_dac, e_flex, e_ext, x;
   int          n_errors, cmp_count, n_pulse;

   ioc_handler uut (.i_mclk, .i_sys_rst, .i_hw_rev_130, .i_timer_clock_source,
      .i_cmd_valid, .i_cmd_byte, .o_cmd_ready, .o_rsp_valid, .o_rsp_byte,
      .i_rsp_ready, .o_timer_counter_setup, .o_second_dac_control,
      .o_flex_port_analog_select, .o_ext_port_analog_select,
      .o_start_pin_offset, .o_first_timer_enable, .o_second_timer_enable,
      .o_first_counter_enable, .o_second_counter_enable, .o_first_timer_line,
      .o_second_timer_line, .o_first_counter_line, .o_second_counter_line,
      .o_second_dac_enable, .o_serial_pins_assigned, .o_timer_mode_reset,
      .o_timer_reset_mode);

   ioc_host_model host (.i_mclk, .i_cmd_ready(o_cmd_ready),
      .i_rsp_valid(o_rsp_valid), .i_rsp_byte(o_rsp_byte),
      .o_cmd_valid(i_cmd_valid), .o_cmd_byte(i_cmd_byte),
      .o_rsp_ready(i_rsp_ready));

   always #12.5 i_mclk = ~i_mclk;

   always @(posedge i_mclk) if (o_timer_mode_reset === 1'b1) n_pulse++;

   // ------------------------------------------------------------------
   // Expectation helpers
   // ------------------------------------------------------------------
   function automatic logic [7:0] rnd();
      lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
      return lfsr[7:0];
   endfunction

   // Fills in both checksums; the header sum folds its carries twice.
   function automatic ioc_pkg::ioc_pkt_t seal(input ioc_pkg::ioc_pkt_t p);
      logic [15:0] s;
      s = 16'h0000;
      for (int i = 6; i < 12; i++) s = s + 16'(p[i]);
      p[4] = s[7:0];
      p[5] = s[15:8];
      s = 16'h0000;
      for (int i = 1; i < 6; i++) s = s + 16'(p[i]);
      s = 16'(s[7:0]) + 16'(s[15:8]);
      p[0] = s[7:0] + s[15:8];
      return p;
   endfunction

   task automatic ck(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
      end
   endtask

   task automatic check_state();
      logic [4:0] off;
      logic [4:0] nt;
      off = {1'b0, e_tc[7:4]};
      nt = {3'h0, e_tc[1:0]};
      ck(32'(o_timer_counter_setup), 32'(e_tc));
      ck(32'(o_start_pin_offset), 32'(e_tc[7:4]));
      ck(32'(o_first_timer_enable), 32'(e_tc[1:0] != 2'h0));
      ck(32'(o_second_timer_enable), 32'(e_tc[1]));
      ck(32'(o_first_counter_enable), 32'(e_tc[2] &&
         !(i_timer_clock_source inside {[3'h3:3'h6]})));
      ck(32'(o_second_counter_enable), 32'(e_tc[3]));
      ck(32'(o_first_timer_line), 32'(off));
      ck(32'(o_second_timer_line), 32'(off + 5'h01));
      ck(32'(o_first_counter_line), 32'(off + nt));
      ck(32'(o_second_counter_line), 32'(off + nt + 5'(e_tc[2])));
      ck(32'(o_second_dac_control), 32'(e_dac));
      ck(32'(o_second_dac_enable), 32'(i_hw_rev_130 | e_dac[0]));
      ck(32'(o_serial_pins_assigned), 32'(i_hw_rev_130 & e_dac[2]));
      ck(32'(o_flex_port_analog_select), 32'(e_flex));
      ck(32'(o_ext_port_analog_select), 32'(e_ext));
      ck(32'(o_timer_reset_mode), 32'h0000_000A);
   endtask

   // ------------------------------------------------------------------
   // One command: build, predict, transfer, compare
   // ------------------------------------------------------------------
   task automatic do_cmd(input logic [7:0] m, tc, b9, fl, ex,
                         input logic [1:0] bad, input logic [7:0] pat);
      ioc_pkg::ioc_pkt_t p, q, r, got;
      logic [7:0] code;
      logic ok;
      int pulses;
      p = '0;
      p[1] = 8'hF8;
      p[2] = 8'h03;
      p[3] = 8'h0B;
      p[6] = m & 8'hEF;
      p[8] = tc;
      p[9] = b9 & 8'h05;
      p[10] = fl;
      p[11] = ex;
      p = seal(p);
      if (bad == 2'h1) p[4] = p[4] ^ 8'h01;
      if (bad == 2'h2) p[2] = 8'h0A;
      if (bad == 2'h2) p = seal(p);
      q = seal(p);
      code = `IOC_ERR_NONE;
      if (q[0] !== p[0] || q[4] !== p[4] || q[5] !== p[5])
         code = `IOC_ERR_SUM;
      else if (p[2] !== 8'h03) code = `IOC_ERR_HDR;
      else if (i_hw_rev_130 && p[6][0] && !(tc[7:4] inside {[4'h4:4'h8]}))
         code = `IOC_ERR_OFFSET;
      else if (p[6][0] && (tc[1:0] == 2'h3 || (tc[2] &&
               i_timer_clock_source inside {[3'h3:3'h6]})))
         code = `IOC_ERR_COMBO;
      if (code == `IOC_ERR_NONE) begin
         if (p[6][0]) e_tc = tc;
         if (p[6][1]) e_dac[0] = p[9][0];
         if (p[6][2]) e_flex = fl;
         if (p[6][3]) e_ext = ex;
         if (p[6][5]) e_dac[2] = p[9][2];
      end
      r = '0;
      r[1] = 8'hF8;
      r[2] = 8'h03;
      r[3] = 8'h0B;
      r[6] = code;
      r[8] = e_tc;
      r[9] = e_dac;
      r[10] = e_flex;
      r[11] = e_ext;
      r = seal(r);
      pulses = n_pulse;
      host.xfer(p, pat, pat[6], got, ok);
      ck(32'(ok), 32'h1);
      for (int i = 0; i < 12; i++) ck(32'(got[i]), 32'(r[i]));
      ck(32'(n_pulse - pulses), 32'(code == 8'h00 && e_tc[1:0] != 2'h0));
      check_state();
   endtask

   task automatic end_sim();
      $display("comparisons %0d, mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask

   initial begin
      repeat (40000) @(posedge i_mclk);
      n_errors++;
      $display("unexpected at %0t: got %0h expected %0h", $time, 0, 1);
      end_sim();
   end

   initial begin
      i_mclk = 1'b0;
      i_sys_rst = 1'b1;
      i_hw_rev_130 = 1'b1;
      i_timer_clock_source = 3'h0;
      lfsr = 32'h8A05;
      e_tc = 8'h40;
      e_dac = 8'h00;
      e_flex = 8'h00;
      e_ext = 8'h00;
      repeat (16) @(posedge i_mclk);
      #1 i_sys_rst = 1'b0;
      repeat (2) @(posedge i_mclk);
      #1 check_state();
      do_cmd(8'h0D, 8'h61, 8'h00, 8'h30, 8'h03, 2'h0, 8'hFF);
      do_cmd(8'h01, 8'h90, 8'h00, 8'h00, 8'h00, 2'h0, 8'h11);
      do_cmd(8'h01, 8'h30, 8'h00, 8'h00, 8'h00, 2'h0, 8'hFF);
      do_cmd(8'h01, 8'h43, 8'h00, 8'h00, 8'h00, 2'h0, 8'h5A);
      do_cmd(8'h1D, 8'h8E, 8'h00, 8'hFF, 8'h81, 2'h0, 8'hFF);
      i_timer_clock_source = 3'h4;
      do_cmd(8'h01, 8'h44, 8'h00, 8'h00, 8'h00, 2'h0, 8'hFF);
      i_timer_clock_source = 3'h0;
      do_cmd(8'h22, 8'h00, 8'h05, 8'h00, 8'h00, 2'h0, 8'h3C);
      do_cmd(8'h02, 8'h00, 8'h04, 8'h00, 8'h00, 2'h0, 8'hFF);
      do_cmd(8'h3F, 8'h41, 8'h00, 8'h11, 8'h22, 2'h1, 8'hFF);
      do_cmd(8'h3F, 8'h41, 8'h00, 8'h11, 8'h22, 2'h2, 8'hFF);
      for (int n = 0; n < 60; n++) begin
         if (n == 40) i_hw_rev_130 = 1'b0;
         x = rnd();
         i_timer_clock_source = x[2:0];
         do_cmd(rnd() & 8'h2F, rnd(), rnd(), rnd(), rnd(),
                x[7:5] == 3'h0 ? 2'h1 : (x[7:5] == 3'h1 ? 2'h2 : 2'h0),
                rnd() | 8'h01);
      end
      end_sim();
   end
endmodule // test_io_config_command_handler
